// ===== hw/hmcg_halt_ctrl.sv
// halt mode standby controller: cpu clock gating, source retention and release wait
`timescale 1ns/1ps
module hmcg_halt_ctrl (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // cpu core side
    input wire logic halt_instr_in,
    input wire hmcg_pkg::hmcg_src_t cpu_clk_sel_in,
    input wire logic int_ack_en_in,
    // interrupt request logic
    input wire logic [hmcg_pkg::HMCG_IRQ_COUNT-1:0] irq_req_in,
    input wire logic [hmcg_pkg::HMCG_IRQ_COUNT-1:0] interrupt_mask_flag_in,
    // clock generator settings held by software
    input wire logic crystal_en_in,
    input wire logic ext_clk_present_in,
    input wire logic low_osc_en_in,
    input wire logic wdt_sw_stoppable_in,
    // gate controls
    output hmcg_pkg::hmcg_clk_gate_t clk_gate_out,
    // status toward the cpu core
    output logic halted_out,
    output logic resume_out,
    output logic vector_out
);
    import hmcg_pkg::*;

    // ----------------------------------------------------------------
    // module state
    // ----------------------------------------------------------------
    typedef struct packed {
        hmcg_state_t state;                  // controller state
        hmcg_src_t sel;                      // cpu clock source caught at entry
        logic xtal;                          // crystal run level caught at entry
        logic losc;                          // low oscillator level caught at entry
        logic vec;                           // servicing decision caught at release
        logic [HMCG_CNT_W-1:0] cnt;          // release wait counter
        hmcg_clk_gate_t gate;                // registered gate controls
        logic halted;                        // registered halt status
        logic resume;                        // one cycle resume pulse
        logic vector;                        // one cycle vectored servicing pulse
    } hmcg_regs_t;

    localparam hmcg_regs_t HMCG_REGS_RST = '{
        state: HMCG_ST_RUN, sel: HMCG_SRC_FAST, xtal: 1'b0, losc: 1'b1, vec: 1'b0,
        cnt: HMCG_CNT_RST, gate: HMCG_GATE_RST, halted: 1'b0, resume: 1'b0, vector: 1'b0};

    hmcg_regs_t r_q;     // registered state
    hmcg_regs_t r_d;     // next state
    logic wake;          // unmasked request pending

    // ----------------------------------------------------------------
    // release source
    // ----------------------------------------------------------------
    hmcg_wake_detect u_wake (
        .irq_req_in(irq_req_in),
        .interrupt_mask_flag_in(interrupt_mask_flag_in),
        .wake_out(wake)
    );

    // gate values for running: cpu on, sources as software sets them
    function automatic hmcg_clk_gate_t run_gate(input hmcg_src_t sel, input logic xtal_en,
                                                input logic ext_in, input logic losc_en);
        hmcg_clk_gate_t g;
        g.cpu_en = 1'b1;
        g.fast_osc_run = 1'b1;
        g.xtal_run = xtal_en | (sel == HMCG_SRC_XTAL);
        g.ext_clk_en = ext_in | (sel == HMCG_SRC_EXT);
        g.low_osc_run = losc_en;
        g.wdt_en = 1'b1;
        g.periph_en = 1'b1;
        g.retain = 1'b0;
        return g;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        r_d.resume = 1'b0;
        r_d.vector = 1'b0;
        unique case (r_q.state)
            HMCG_ST_RUN: begin
                r_d.gate = run_gate(cpu_clk_sel_in, crystal_en_in, ext_clk_present_in,
                                    low_osc_en_in);
                // entry only on the instruction, whatever clock the cpu used
                if (halt_instr_in) begin
                    r_d.state = HMCG_ST_HALT;
                    r_d.sel = cpu_clk_sel_in;
                    r_d.xtal = crystal_en_in;
                    r_d.losc = low_osc_en_in;
                    r_d.halted = 1'b1;
                    r_d.gate.cpu_en = 1'b0;
                    r_d.gate.retain = 1'b1;
                    r_d.gate.wdt_en = ~wdt_sw_stoppable_in;
                end
            end
            HMCG_ST_HALT: begin
                r_d.gate.cpu_en = 1'b0;
                r_d.gate.fast_osc_run = 1'b1;
                // crystal held as before entry unless it feeds the cpu
                r_d.gate.xtal_run = r_q.xtal | (r_q.sel == HMCG_SRC_XTAL);
                // external input follows the pin unless it feeds the cpu
                r_d.gate.ext_clk_en = ext_clk_present_in | (r_q.sel == HMCG_SRC_EXT);
                r_d.gate.low_osc_run = r_q.losc;
                r_d.gate.retain = 1'b1;
                r_d.gate.periph_en = 1'b1;
                r_d.gate.wdt_en = ~wdt_sw_stoppable_in;
                // a masked request leaves wake low, so the core stays here
                if (wake) begin
                    r_d.state = HMCG_ST_WAIT;
                    r_d.vec = int_ack_en_in;
                    r_d.cnt = int_ack_en_in ? HMCG_LOAD_VEC : HMCG_LOAD_NOVEC;
                end
            end
            HMCG_ST_WAIT: begin
                // sources stay as in halt until execution resumes
                r_d.gate.ext_clk_en = ext_clk_present_in | (r_q.sel == HMCG_SRC_EXT);
                r_d.gate.wdt_en = ~wdt_sw_stoppable_in;
                r_d.cnt = r_q.cnt - HMCG_CNT_LAST;
                if (r_q.cnt == HMCG_CNT_LAST) begin
                    r_d.state = HMCG_ST_RUN;
                    r_d.halted = 1'b0;
                    r_d.resume = 1'b1;
                    r_d.vector = r_q.vec;
                    r_d.gate = run_gate(cpu_clk_sel_in, crystal_en_in, ext_clk_present_in,
                                        low_osc_en_in);
                end
            end
            // an illegal code falls back to running
            default: begin
                r_d = HMCG_REGS_RST;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register; reset ends halt and returns to running at once
    // ----------------------------------------------------------------
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_q <= HMCG_REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from the state flops
    assign clk_gate_out = r_q.gate;
    assign halted_out = r_q.halted;
    assign resume_out = r_q.resume;
    assign vector_out = r_q.vector;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_halt_wake_vec;
        (r_q.state == HMCG_ST_HALT) && wake && int_ack_en_in;
    endsequence

    sequence s_halt_wake_novec;
        (r_q.state == HMCG_ST_HALT) && wake && !int_ack_en_in;
    endsequence

    a_halt_entry_cause: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        $rose(halted_out) |-> $past(halt_instr_in))
        else $error("halt entered without the halt instruction");

    a_entry_any_src: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (r_q.state == HMCG_ST_RUN) && halt_instr_in |=> halted_out && !clk_gate_out.cpu_en)
        else $error("halt instruction did not enter halt");

    a_cpu_clk_gated: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        halted_out |-> !clk_gate_out.cpu_en)
        else $error("cpu clock running while halted");

    a_fast_osc_on: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        clk_gate_out.fast_osc_run)
        else $error("fast oscillator stopped");

    a_xtal_forced_on: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        halted_out && (r_q.sel == HMCG_SRC_XTAL) |-> clk_gate_out.xtal_run)
        else $error("crystal stopped while feeding the halted cpu");

    a_xtal_state_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (r_q.state == HMCG_ST_HALT) ##1 (r_q.state == HMCG_ST_HALT)
        |-> $stable(clk_gate_out.xtal_run))
        else $error("crystal state changed during halt");

    a_ext_clk_follow: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (r_q.state == HMCG_ST_HALT) && (r_q.sel != HMCG_SRC_EXT)
        |=> clk_gate_out.ext_clk_en == $past(ext_clk_present_in))
        else $error("external clock gate does not follow its input");

    a_retain_in_halt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        halted_out |-> clk_gate_out.retain && (clk_gate_out.low_osc_run == r_q.losc))
        else $error("retention lost during halt");

    a_wdt_stop_opt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (r_q.state == HMCG_ST_HALT) |=> clk_gate_out.wdt_en == !$past(wdt_sw_stoppable_in)
        && clk_gate_out.periph_en)
        else $error("watchdog or peripheral clock wrong in halt");

    // no early resume over the first eight cycles, the pulse lands on the eleventh
    a_wake_vec_wait: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        s_halt_wake_vec |=> !resume_out [*8] ##3 (resume_out && vector_out))
        else $error("vectored release wait is not 11 clocks");

    a_wake_novec_wait: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        s_halt_wake_novec |-> ##4 (resume_out && !vector_out && clk_gate_out.cpu_en))
        else $error("plain release wait is not 4 clocks");

    a_mask_holds_halt: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (r_q.state == HMCG_ST_HALT) && !wake |=> halted_out && (r_q.state == HMCG_ST_HALT))
        else $error("halt released without an unmasked request");
endmodule

// ===== hw/hmcg_pkg.sv
// shared constants, state codes and carrier structs of the halt clock gating block
package hmcg_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int HMCG_CLK_PERIOD_NS = 20;          // system clock period, 50 mhz
    localparam int HMCG_WAIT_VEC_CLOCKS = 11;        // release wait, vectored servicing
    localparam int HMCG_WAIT_NOVEC_CLOCKS = 4;       // release wait, next instruction
    localparam int HMCG_CNT_W = 4;                   // wide enough for the longer wait
    localparam logic [HMCG_CNT_W-1:0] HMCG_LOAD_VEC = HMCG_CNT_W'(HMCG_WAIT_VEC_CLOCKS - 1);
    localparam logic [HMCG_CNT_W-1:0] HMCG_LOAD_NOVEC = HMCG_CNT_W'(HMCG_WAIT_NOVEC_CLOCKS - 1);
    localparam logic [HMCG_CNT_W-1:0] HMCG_CNT_LAST = 4'h1;   // last wait cycle
    localparam logic [HMCG_CNT_W-1:0] HMCG_CNT_RST = 4'h0;    // counter after reset

    // ----------------------------------------------------------------
    // interrupt sources
    // ----------------------------------------------------------------
    localparam int HMCG_IRQ_COUNT = 8;               // maskable request lines watched

    // ----------------------------------------------------------------
    // state and clock source codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        HMCG_ST_RUN = 3'h1,                          // cpu clocked, executing
        HMCG_ST_HALT = 3'h2,                         // cpu clock gated off
        HMCG_ST_WAIT = 3'h4                          // released, counting the wait
    } hmcg_state_t;

    typedef enum logic [1:0] {
        HMCG_SRC_FAST = 2'h0,                        // internal fast oscillator
        HMCG_SRC_XTAL = 2'h1,                        // crystal oscillator
        HMCG_SRC_EXT = 2'h2                          // external main clock input
    } hmcg_src_t;

    // ----------------------------------------------------------------
    // carrier of the clock gate controls
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cpu_en;                                // clock enable to the cpu core
        logic fast_osc_run;                          // internal fast oscillator run
        logic xtal_run;                              // crystal oscillator run
        logic ext_clk_en;                            // external main clock input gate
        logic low_osc_run;                           // low speed oscillator run
        logic wdt_en;                                // watchdog clock enable
        logic periph_en;                             // timers, watch timer, converter
        logic retain;                                // freeze ram, flash and port latches
    } hmcg_clk_gate_t;

    localparam hmcg_clk_gate_t HMCG_GATE_RST = 8'hde; // all running but the crystal, retain off

endpackage

// ===== hw/hmcg_wake_detect.sv
// unmasked interrupt request detector that releases the halt state
`timescale 1ns/1ps
module hmcg_wake_detect (
    // request lines and their masks
    input wire logic [hmcg_pkg::HMCG_IRQ_COUNT-1:0] irq_req_in,
    input wire logic [hmcg_pkg::HMCG_IRQ_COUNT-1:0] interrupt_mask_flag_in,
    // release request
    output logic wake_out
);
    import hmcg_pkg::*;

    logic [HMCG_IRQ_COUNT-1:0] unmasked; // per line request that passes its mask

    // ----------------------------------------------------------------
    // per line gating; a set mask keeps the core halted whatever the priority
    // ----------------------------------------------------------------
    for (genvar i = 0; i < HMCG_IRQ_COUNT; i++) begin : g_line
        assign unmasked[i] = irq_req_in[i] & ~interrupt_mask_flag_in[i];
    end

    assign wake_out = |unmasked;
endmodule

// ===== tb/hmcg_cpu_model.sv
// cpu core stand-in that issues the halt instruction as a one-cycle pulse
`timescale 1ns/1ps
module hmcg_cpu_model (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // bench request and release status
    input wire logic halt_req_in,
    input wire logic resume_in,
    // halt instruction toward the controller
    output logic halt_instr_out
);
    logic running_q; // core executing, may fetch a halt
    logic fire; // halt issued at this edge
    assign fire = halt_req_in & running_q & ~halt_instr_out;
    // a halted core fetches nothing, so a second halt never follows the first
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            running_q <= 1'b1;
            halt_instr_out <= 1'b0;
        end else begin
            halt_instr_out <= fire;
            if (fire) begin
                running_q <= 1'b0;
            end else if (resume_in) begin
                running_q <= 1'b1;
            end
        end
    end
endmodule

// ===== tb/hmcg_halt_ctrl_test.sv
// self-checking bench of the halt controller with a cpu stand-in
`timescale 1ns/1ps
module hmcg_halt_ctrl_test;
    import hmcg_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clock_in, rst_n_in, halt_req, halt_instr, ack_en;
    logic [HMCG_IRQ_COUNT-1:0] irq, mask;
    logic cry_en, ext_on, low_en, stoppable, halted, resume, vector;
    logic [1:0] sel; // raw source code, 3 included as a corner
    hmcg_clk_gate_t gate;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0; // hang guard
    logic [31:0] seed = 32'h00018568;
    hmcg_halt_ctrl hmcg_halt_ctrl_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .halt_instr_in(halt_instr), .cpu_clk_sel_in(hmcg_src_t'(sel)), .int_ack_en_in(ack_en),
        .irq_req_in(irq), .interrupt_mask_flag_in(mask), .crystal_en_in(cry_en),
        .ext_clk_present_in(ext_on), .low_osc_en_in(low_en), .wdt_sw_stoppable_in(stoppable),
        .clk_gate_out(gate), .halted_out(halted), .resume_out(resume), .vector_out(vector));
    hmcg_cpu_model hmcg_cpu_model_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .halt_req_in(halt_req), .resume_in(resume), .halt_instr_out(halt_instr));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // gate pattern while halted, worked out from the entry settings and the present external input
    function automatic hmcg_clk_gate_t halt_gate();
        hmcg_clk_gate_t g;
        g = '{1'b0, 1'b1, cry_en | (sel == 2'h1), ext_on | (sel == 2'h2), low_en,
              ~stoppable, 1'b1, 1'b1};
        return g;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // request a halt from the cpu stand-in and wait for the controller
    task automatic enter_halt();
        @(posedge clock_in);
        mask <= 8'hff;
        halt_req <= 1'b1;
        for (int i = 0; i < 10 && halted !== 1'b1; i++) begin
            @(posedge clock_in);
            #1;
        end
        @(posedge clock_in);
        halt_req <= 1'b0;
        #1;
    endtask
    // one pass: idle requests, halt, masked requests, then a release
    task automatic run_one(input int k);
        logic [31:0] r;
        logic [7:0] bit1;
        logic [7:0] want;
        int n;
        r = xs();
        bit1 = 8'h01 << r[26:24];
        @(posedge clock_in);
        sel <= (k < 4) ? 2'(k) : r[1:0];
        ack_en <= (k < 4) ? k[0] : r[6];
        {cry_en, ext_on, low_en, stoppable} <= r[5:2];
        irq <= r[15:8];
        mask <= r[23:16];
        repeat (3) @(posedge clock_in);
        #1;
        check({7'h0, halted}, 8'h00, "halted without halt instruction");
        enter_halt();
        check({7'h0, halted}, 8'h01, "halt entry");
        check(gate, halt_gate(), "gate pattern in halt");
        @(posedge clock_in);
        irq <= r[15:8] | 8'h80;
        ext_on <= r[27]; // external input may come and go while halted
        repeat (15) begin
            @(posedge clock_in);
            #1;
            check({halted, resume}, 8'h02, "masked request");
        end
        check(gate, halt_gate(), "gate pattern held");
        @(posedge clock_in);
        irq <= irq | bit1;
        mask <= ~bit1;
        n = 0;
        do begin
            @(posedge clock_in);
            #1;
            n++;
        end while (resume !== 1'b1 && n < 30);
        want = ack_en ? 8'(HMCG_WAIT_VEC_CLOCKS) : 8'(HMCG_WAIT_NOVEC_CLOCKS);
        check(8'(n), want, "release wait");
        check({vector, halted, gate.cpu_en, gate.retain}, {ack_en, 3'h2}, "release");
        @(posedge clock_in);
        irq <= 8'h00;
    endtask
    // ------------------------------------------------------------
    // clock, guard and main sequence
    // ------------------------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    // the full run needs under 2000 cycles
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        {rst_n_in, halt_req, ack_en, irq, mask, sel} = '0;
        {cry_en, ext_on, low_en, stoppable} = 4'h0;
        repeat (5) @(posedge clock_in);
        check(gate, HMCG_GATE_RST, "gate in reset");
        rst_n_in <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            run_one(k);
        end
        enter_halt();
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        #1;
        check(gate, HMCG_GATE_RST, "gate on reset while halted");
        check({7'h0, halted}, 8'h00, "halt left on reset");
        @(posedge clock_in);
        rst_n_in <= 1'b1;
        enter_halt();
        check({7'h0, halted}, 8'h01, "halt after reset");
        give_verdict();
    end
endmodule
